// ==== dv/bkp_assertions.sv ====
// Port-level checks of the breakpoint unit
`timescale 1ns/1ns
module bkp_assertions (
  input wire logic        clk_i,        // Clock
  input wire logic        rst_i,        // Reset
  input wire logic        wb_cyc_i,     // Cycle
  input wire logic        wb_stb_i,     // Strobe
  input wire logic        wb_we_i,      // Write
  input wire logic [17:0] wb_adr_i,     // Address
  input wire logic [3:0]  wb_sel_i,     // Selects
  input wire logic [31:0] wb_dat_i,     // Write data
  input wire logic        wb_ack_o,     // Ack
  input wire logic [15:0] cpu_addr_i,   // CPU address
  input wire logic        cpu_cycle_i,  // Bus cycle
  input wire logic        cpu_rti_i,    // Return
  input wire logic        bkp_match_o,  // Match
  input wire logic        brk_start_o,  // Start
  input wire logic        brk_state_o,  // Break
  input wire logic        timer_stop_o, // Timers
  input wire logic        clr_allow_o,  // Clear allowed
  input wire logic        irq_o         // Interrupt
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] bp_r;
  logic [15:0] idx;
  logic        en_r;
  logic        cfe_r;
  logic        wr;
  logic        hit;
  assign idx = wb_adr_i[17:2];
  assign wr  = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];
  assign hit = cpu_cycle_i & en_r & (cpu_addr_i == bp_r);
  // Shadow of the registers the checks depend on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bp_r  <= 16'h0000;
      en_r  <= 1'b0;
      cfe_r <= 1'b0;
    end else if (wr) begin
      if (idx == bkp_pkg::IDX_BP_HIGH)
        bp_r[15:8] <= wb_dat_i[7:0];
      if (idx == bkp_pkg::IDX_BP_LOW)
        bp_r[7:0] <= wb_dat_i[7:0];
      if (idx == bkp_pkg::IDX_STATUS_CTRL)
        en_r <= wb_dat_i[7];
      if (idx == bkp_pkg::IDX_FLAG_CLEAR)
        cfe_r <= wb_dat_i[7];
    end
  end
  AST_MATCH: assert property (hit |=> bkp_match_o)
    else $error("match pulse missing");
  AST_NO_MATCH: assert property (!hit |=> !bkp_match_o)
    else $error("match pulse without a match");
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not acknowledged");
  AST_START: assert property (brk_start_o |-> brk_state_o)
    else $error("break start without break state");
  AST_TIMER: assert property ($rose(timer_stop_o) |-> brk_start_o)
    else $error("timers stopped without a break start");
  AST_END: assert property (brk_state_o && cpu_rti_i |=> !brk_state_o)
    else $error("break state kept after return");
  AST_HOLD: assert property (brk_state_o && !cpu_rti_i |=> brk_state_o)
    else $error("break state left early");
  AST_CLR: assert property (brk_state_o && cfe_r == $past(cfe_r) |->
    clr_allow_o == cfe_r) else $error("clear allow wrong in break");
  AST_FREE: assert property (!brk_state_o && !$past(brk_state_o) |->
    clr_allow_o) else $error("clear blocked outside break");
  COV_MATCH: cover property (bkp_match_o ##1 brk_start_o);
  COV_START: cover property (brk_start_o);
  COV_IRQ: cover property (irq_o);
endmodule : bkp_assertions

// ==== dv/bkp_cpu_model.sv ====
// Behavioural model of the CPU core facing the breakpoint unit
`timescale 1ns/1ns
module bkp_cpu_model (
  input  wire logic        clk_i,   // System clock
  input  wire logic        rst_i,   // Sync reset
  input  wire logic        hit_i,   // Put target on the bus
  input  wire logic        fix_i,   // Last flag taken from last_i
  input  wire logic        last_i,  // Last flag when fixed
  input  wire logic        slow_i,  // Slow break routine
  input  wire logic [15:0] tgt_i,   // Breakpoint target
  input  wire logic        brk_i,   // Break state
  output logic      [15:0] addr_o,  // CPU address
  output logic             cycle_o, // Address valid
  output logic             last_o,  // Last instruction cycle
  output logic             rti_o    // Return executed
);
  logic [15:0] rnd_r;
  logic [4:0]  wait_r;
  always @(posedge clk_i) rnd_r <= 16'($urandom);
  // Random traffic never lands on the target unless asked to
  assign addr_o  = hit_i ? tgt_i : tgt_i ^ {rnd_r[15:1], 1'b1};
  assign cycle_o = hit_i | rnd_r[3];
  assign last_o  = fix_i ? last_i : rnd_r[5];
  // Break routine ends with one return after a short or long wait
  always @(posedge clk_i) begin
    rti_o <= brk_i && wait_r == 5'd1;
    if (rst_i || !brk_i)
      wait_r <= slow_i ? 5'd20 : 5'd2;
    else if (wait_r != 5'd0)
      wait_r <= wait_r - 5'd1;
  end
endmodule : bkp_cpu_model

// ==== dv/test_address_breakpoint_unit.sv ====
// Self-checking bench of the address breakpoint unit
`timescale 1ns/1ns
module test_address_breakpoint_unit;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [17:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] cpu_addr_i, bp;
  logic        cpu_cycle_i, cpu_last_i, cpu_rti_i, cpu_lowpwr_i;
  logic        bkp_match_o, brk_start_o, brk_state_o, timer_stop_o;
  logic        clr_allow_o, irq_o, hit, fix, last, slow, m;
  logic [7:0]  q, d, cfe;
  int          mismatches = 0, check_count = 0, cycles = 0, n, starts = 0;
  logic [15:0] idx [8] = '{bkp_pkg::IDX_WAKE_STATUS,
    bkp_pkg::IDX_FLAG_CLEAR, bkp_pkg::IDX_BP_HIGH, bkp_pkg::IDX_BP_LOW,
    bkp_pkg::IDX_STATUS_CTRL, bkp_pkg::IDX_INT_STATUS,
    bkp_pkg::IDX_INT_MASK, 16'h0123};
  bkp_top DUT (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .cpu_addr_i, .cpu_cycle_i,
    .cpu_last_i, .cpu_rti_i, .cpu_lowpwr_i, .bkp_match_o, .brk_start_o,
    .brk_state_o, .timer_stop_o, .clr_allow_o, .irq_o);
  bkp_cpu_model u_cpu (
    .clk_i, .rst_i, .hit_i(hit), .fix_i(fix), .last_i(last),
    .slow_i(slow), .tgt_i(bp), .brk_i(brk_state_o), .addr_o(cpu_addr_i),
    .cycle_o(cpu_cycle_i), .last_o(cpu_last_i), .rti_o(cpu_rti_i));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input string s, input logic [31:0] v, e);
    check_count++;
    if (v !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  // Start pulses counted at the edge that samples them
  always @(posedge clk_i) begin
    if (brk_start_o === 1'b1) starts++;
  end
  // Expected status/control read value
  function automatic logic [7:0] ctrl_exp(input logic en, input logic act);
    ctrl_exp = 8'h00;
    ctrl_exp[bkp_pkg::BIT_BP_ENABLE]    = en;
    ctrl_exp[bkp_pkg::BIT_BREAK_ACTIVE] = act;
  endfunction : ctrl_exp
  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic we, input logic [15:0] a, input logic [7:0] w);
    int k;
    k = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= {a, 2'b00};
    wb_dat_i <= {24'h00_0000, w};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (k >= 20) chk("wb_ack", 1'b0, 1'b1);
  endtask : wb
  task automatic rd(input string s, input logic [15:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(s, q, e);
  endtask : rd
  // Match or forced break; last flag raised dl cycles after compare
  task automatic brk(input int dl, input logic sw);
    int s;
    s = starts;
    fix <= 1'b1;
    last <= (dl == 0);
    m = 1'b0;
    n = 0;
    if (sw) wb(1'b1, bkp_pkg::IDX_STATUS_CTRL, 8'hC0);
    else begin
      @(posedge clk_i);
      hit <= 1'b1;
      @(posedge clk_i);
      hit <= 1'b0;
      #1;
      m = bkp_match_o;
    end
    for (int k = 1; k <= 40; k++) begin
      @(posedge clk_i);
      if (k == dl) last <= 1'b1;
      #1;
      if (brk_start_o === 1'b1 && n == 0) n = k;
      if (brk_state_o === 1'b1) chk("clr_allow", clr_allow_o, cfe[7]);
    end
    // Forced start pulses counted over the write and the 40 cycles after it
    if (sw) n = starts - s;
    chk("break_end", brk_state_o, 1'b0);
    @(posedge clk_i);
    fix <= 1'b0;
  endtask : brk
  initial begin
    void'($urandom(32'hf622_de98));
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {hit, fix, last, slow, cpu_lowpwr_i, bp} = '0;
    wb_sel_i = 4'h1;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (idx[i]) rd("reset", idx[i], 8'h00);
    $display("test reset done");
    bp = 16'($urandom);
    d = 8'($urandom);
    cfe = {d[7], 7'h00};
    wb(1'b1, bkp_pkg::IDX_FLAG_CLEAR, d);
    wb(1'b1, bkp_pkg::IDX_BP_HIGH, bp[15:8]);
    wb(1'b1, bkp_pkg::IDX_BP_LOW, bp[7:0]);
    wb(1'b1, 16'h0123, 8'hFF);
    rd("bp_high", bkp_pkg::IDX_BP_HIGH, bp[15:8]);
    rd("bp_low", bkp_pkg::IDX_BP_LOW, bp[7:0]);
    rd("flag_clear", bkp_pkg::IDX_FLAG_CLEAR, cfe);
    rd("unmapped", 16'h0123, 8'h00);
    wb_sel_i <= 4'h0;
    wb(1'b1, bkp_pkg::IDX_BP_HIGH, ~bp[15:8]);
    wb_sel_i <= 4'h1;
    rd("sel_off", bkp_pkg::IDX_BP_HIGH, bp[15:8]);
    $display("test registers done");
    brk(0, 1'b0);
    chk("match_off", {m, n[7:0]}, 9'h000);
    wb(1'b1, bkp_pkg::IDX_STATUS_CTRL, 8'h80);
    rd("enable", bkp_pkg::IDX_STATUS_CTRL, ctrl_exp(1'b1, 1'b0));
    brk(0, 1'b0);
    chk("match_on", m, 1'b1);
    chk("start_now", n, 1);
    rd("active", bkp_pkg::IDX_STATUS_CTRL, ctrl_exp(1'b1, 1'b1));
    rd("no_wake", bkp_pkg::IDX_WAKE_STATUS, 8'h00);
    wb(1'b1, bkp_pkg::IDX_STATUS_CTRL, 8'h80);
    rd("active_clr", bkp_pkg::IDX_STATUS_CTRL, ctrl_exp(1'b1, 1'b0));
    brk(5, 1'b0);
    chk("start_late", n > 5 && n < 8, 1'b1);
    wb(1'b1, bkp_pkg::IDX_STATUS_CTRL, 8'h80);
    $display("test match done");
    cfe = ~cfe & 8'h80;
    wb(1'b1, bkp_pkg::IDX_FLAG_CLEAR, cfe);
    {cpu_lowpwr_i, slow} <= 2'b11;
    brk(0, 1'b1);
    chk("sw_start", n, 1);
    cpu_lowpwr_i <= 1'b0;
    rd("wake", bkp_pkg::IDX_WAKE_STATUS, 8'h02);
    wb(1'b1, bkp_pkg::IDX_WAKE_STATUS, 8'h00);
    rd("wake_clr", bkp_pkg::IDX_WAKE_STATUS, 8'h00);
    wb(1'b1, bkp_pkg::IDX_STATUS_CTRL, 8'h00);
    rd("disable", bkp_pkg::IDX_STATUS_CTRL, ctrl_exp(1'b0, 1'b0));
    $display("test forced break done");
    rd("int_status", bkp_pkg::IDX_INT_STATUS, 8'h07);
    // A mask bit of one lets its status bit through
    chk("irq_masked", irq_o, 1'b0);
    wb(1'b1, bkp_pkg::IDX_INT_MASK, 8'h07);
    chk("irq_on", irq_o, 1'b1);
    wb(1'b1, bkp_pkg::IDX_INT_STATUS, 8'h07);
    rd("int_clear", bkp_pkg::IDX_INT_STATUS, 8'h00);
    chk("irq_off", irq_o, 1'b0);
    wb(1'b1, bkp_pkg::IDX_INT_MASK, 8'h00);
    $display("test interrupt done");
    conclude();
  end
endmodule : test_address_breakpoint_unit
bind bkp_top bkp_assertions u_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .cpu_addr_i, .cpu_cycle_i, .cpu_rti_i,
  .bkp_match_o, .brk_start_o, .brk_state_o, .timer_stop_o, .clr_allow_o,
  .irq_o);

// ==== pkg/bkp_cmp_if.sv ====
// Signals between the control logic and the address comparator
`timescale 1ns/1ns
interface bkp_cmp_if;
  logic [15:0] cpu_addr;
  logic [15:0] bp_addr;
  logic        bus_cycle;
  logic        enable;
  logic        match;

  modport cmp (
    input  cpu_addr,
    input  bp_addr,
    input  bus_cycle,
    input  enable,
    output match
  );

  modport ctl (
    output cpu_addr,
    output bp_addr,
    output bus_cycle,
    output enable,
    input  match
  );
endinterface : bkp_cmp_if

// ==== pkg/bkp_pkg.sv ====
// Constants, register map and types of the address breakpoint unit
package bkp_pkg;

  // Wishbone widths
  localparam int ADR_W = 18;
  localparam int DAT_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_WAKE_STATUS = 16'hFE00;
  localparam logic [15:0] IDX_FLAG_CLEAR  = 16'hFE03;
  localparam logic [15:0] IDX_BP_HIGH     = 16'hFE0C;
  localparam logic [15:0] IDX_BP_LOW      = 16'hFE0D;
  localparam logic [15:0] IDX_STATUS_CTRL = 16'hFE0E;
  localparam logic [15:0] IDX_INT_STATUS  = 16'hFE10;
  localparam logic [15:0] IDX_INT_MASK    = 16'hFE11;

  // Field positions
  localparam int BIT_BP_ENABLE     = 7;
  localparam int BIT_BREAK_ACTIVE  = 6;
  localparam int BIT_EXITED_LP     = 1;
  localparam int BIT_CLEAR_FLAG_EN = 7;

  // Interrupt status layout
  localparam int INT_W     = 3;
  localparam int INT_MATCH = 0;
  localparam int INT_BREAK = 1;
  localparam int INT_WAKE  = 2;

  // Values after reset
  localparam logic [7:0]       RST_BYTE = 8'h00;
  localparam logic [15:0]      RST_ADDR = 16'h0000;
  localparam logic [INT_W-1:0] RST_INT  = 3'h0;
  localparam logic [DAT_W-1:0] RST_DATA = 32'h0000_0000;

  typedef enum logic [1:0] {
    BKP_IDLE,
    BKP_PENDING,
    BKP_ACTIVE
  } bkp_state_e;

endpackage : bkp_pkg

// ==== src/bkp_cmp.sv ====
// Sixteen-bit breakpoint address comparator
`timescale 1ns/1ns
module bkp_cmp (
  input  wire logic clk_i,    // System clock
  input  wire logic rst_i,    // Synchronous reset, active high
  bkp_cmp_if.cmp    cmp_if    // Compare inputs and match pulse
);

  // One-cycle pulse per matching bus cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_if.match <= 1'b0;
    end else begin
      cmp_if.match <= cmp_if.bus_cycle & cmp_if.enable &
                      (cmp_if.cpu_addr == cmp_if.bp_addr);
    end
  end

endmodule : bkp_cmp

// ==== src/bkp_irq.sv ====
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ns
module bkp_irq (
  input  wire logic                     clk_i,     // System clock
  input  wire logic                     rst_i,     // Sync reset, high
  input  wire logic [bkp_pkg::INT_W-1:0] event_i,  // Event pulses
  input  wire logic                     wr_stat_i, // Status write strobe
  input  wire logic                     wr_mask_i, // Mask write strobe
  input  wire logic [bkp_pkg::INT_W-1:0] wdata_i,  // Write data
  output logic      [bkp_pkg::INT_W-1:0] status_o, // Sticky status
  output logic      [bkp_pkg::INT_W-1:0] mask_o,   // Mask register
  output logic                          irq_o      // Level interrupt
);

  logic [bkp_pkg::INT_W-1:0] status_nxt;

  // Write one to clear; a new event wins over the clear
  always_comb begin
    status_nxt = status_o;
    if (wr_stat_i) begin
      status_nxt = status_nxt & ~wdata_i;
    end
    status_nxt = status_nxt | event_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= bkp_pkg::RST_INT;
    end else begin
      status_o <= status_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_o <= bkp_pkg::RST_INT;
    end else if (wr_mask_i) begin
      mask_o <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_nxt & (wr_mask_i ? wdata_i : mask_o));
    end
  end

endmodule : bkp_irq

// ==== src/bkp_top.sv ====
// Address breakpoint unit with Wishbone register access
// How it works
// - Enabled breakpoint raises a break when all sixteen address bits match.
// - Enable is bit 7 of status/control, read/write, reset to zero.
// - Break active bit sets on an enabled match, reads back one.
// - Software writing one to break active forces a break request.
// - Writing zero clears break active; reset clears it too.
// - Breakpoint address held as high and low byte registers.
// - Reset clears both breakpoint address bytes.
// - Flag sets when a break takes the part out of stop or wait.
// - Low-power exit flag clears on zero write, resets to zero, readable.
// - In break state status clearing is allowed only with clear-flag enable.
// - Flag clear control register holds clear-flag enable in bit 7.
// - Break starts after current instruction, at once on its last cycle.
// - Timer counters are told to stop while a break is active.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ns
module bkp_top (
  input  wire logic                      clk_i,       // System clock
  input  wire logic                      rst_i,       // Sync reset, high
  input  wire logic                      wb_cyc_i,    // Wishbone cycle
  input  wire logic                      wb_stb_i,    // Wishbone strobe
  input  wire logic                      wb_we_i,     // Write enable
  input  wire logic [bkp_pkg::ADR_W-1:0] wb_adr_i,    // Byte address
  input  wire logic [3:0]                wb_sel_i,    // Byte selects
  input  wire logic [bkp_pkg::DAT_W-1:0] wb_dat_i,    // Write data
  output logic      [bkp_pkg::DAT_W-1:0] wb_dat_o,    // Read data
  output logic                           wb_ack_o,    // Acknowledge
  input  wire logic [15:0]               cpu_addr_i,  // CPU address
  input  wire logic                      cpu_cycle_i, // Address valid
  input  wire logic                      cpu_last_i,  // Last instr cycle
  input  wire logic                      cpu_rti_i,   // Return executed
  input  wire logic                      cpu_lowpwr_i,// In stop or wait
  output logic                           bkp_match_o, // Match pulse
  output logic                           brk_start_o, // Break start pulse
  output logic                           brk_state_o, // In break state
  output logic                           timer_stop_o,// Stop timers
  output logic                           clr_allow_o, // Flag clear allowed
  output logic                           irq_o        // Interrupt level
);

  bkp_cmp_if cmp_if ();

  logic [7:0]                bp_high_r;
  logic [7:0]                bp_low_r;
  logic                      bp_enable_r;
  logic                      break_active_r;
  logic                      exited_lp_r;
  logic                      clear_flag_en_r;
  logic                      last_d_r;
  logic                      brk_start_r;
  logic                      in_break_r;
  logic                      clr_allow_r;
  logic                      ack_r;
  logic [bkp_pkg::DAT_W-1:0] rdata_r;
  bkp_pkg::bkp_state_e       state_r;
  bkp_pkg::bkp_state_e       state_nxt;
  logic                      start_nxt;
  logic                      req;
  logic                      wr;
  logic [7:0]                wbyte;
  logic                      sw_force;
  logic                      ev_any;
  logic                      ev_now;
  logic [bkp_pkg::INT_W-1:0] int_status;
  logic [bkp_pkg::INT_W-1:0] int_mask;
  logic [bkp_pkg::INT_W-1:0] int_event;

  // Register index decode
  function automatic logic hit(input logic [bkp_pkg::ADR_W-1:0] adr,
                               input logic [15:0]               idx);
    hit = (adr[bkp_pkg::ADR_W-1:2] == idx);
  endfunction : hit

  assign req   = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr    = req & wb_we_i & wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  // Comparator connection
  assign cmp_if.cpu_addr  = cpu_addr_i;
  assign cmp_if.bp_addr   = {bp_high_r, bp_low_r};
  assign cmp_if.bus_cycle = cpu_cycle_i;
  assign cmp_if.enable    = bp_enable_r;

  bkp_cmp u_cmp (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cmp_if (cmp_if)
  );

  assign sw_force = wr & hit(wb_adr_i, bkp_pkg::IDX_STATUS_CTRL) &
                    wbyte[bkp_pkg::BIT_BREAK_ACTIVE];
  assign ev_any   = cmp_if.match | sw_force;
  // Match pulse trails the compare by one cycle, so use delayed last flag
  assign ev_now   = (cmp_if.match & last_d_r) |
                    (sw_force & cpu_last_i);

  // Break sequencing
  always_comb begin
    state_nxt = state_r;
    start_nxt = 1'b0;
    unique case (state_r)
      bkp_pkg::BKP_IDLE: begin
        if (ev_now) begin
          state_nxt = bkp_pkg::BKP_ACTIVE;
          start_nxt = 1'b1;
        end else if (ev_any) begin
          state_nxt = bkp_pkg::BKP_PENDING;
        end
      end
      bkp_pkg::BKP_PENDING: begin
        if (cpu_last_i) begin
          state_nxt = bkp_pkg::BKP_ACTIVE;
          start_nxt = 1'b1;
        end
      end
      bkp_pkg::BKP_ACTIVE: begin
        if (cpu_rti_i) begin
          state_nxt = bkp_pkg::BKP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r     <= bkp_pkg::BKP_IDLE;
      brk_start_r <= 1'b0;
      in_break_r  <= 1'b0;
      last_d_r    <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      brk_start_r <= start_nxt;
      in_break_r  <= (state_nxt == bkp_pkg::BKP_ACTIVE);
      last_d_r    <= cpu_last_i;
    end
  end

  // Status bits may be cleared outside break or with the enable set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_allow_r <= 1'b1;
    end else begin
      clr_allow_r <= (state_nxt != bkp_pkg::BKP_ACTIVE) |
                     clear_flag_en_r;
    end
  end

  // Breakpoint address bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bp_high_r <= bkp_pkg::RST_BYTE;
      bp_low_r  <= bkp_pkg::RST_BYTE;
    end else begin
      if (wr & hit(wb_adr_i, bkp_pkg::IDX_BP_HIGH)) begin
        bp_high_r <= wbyte;
      end
      if (wr & hit(wb_adr_i, bkp_pkg::IDX_BP_LOW)) begin
        bp_low_r <= wbyte;
      end
    end
  end

  // Enable and break active
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bp_enable_r    <= 1'b0;
      break_active_r <= 1'b0;
    end else begin
      if (wr & hit(wb_adr_i, bkp_pkg::IDX_STATUS_CTRL)) begin
        bp_enable_r <= wbyte[bkp_pkg::BIT_BP_ENABLE];
      end
      if (cmp_if.match) begin
        break_active_r <= 1'b1;
      end else if (wr & hit(wb_adr_i, bkp_pkg::IDX_STATUS_CTRL)) begin
        break_active_r <= wbyte[bkp_pkg::BIT_BREAK_ACTIVE];
      end
    end
  end

  // Low-power exit flag; a new exit wins over a clearing write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exited_lp_r <= 1'b0;
    end else if (start_nxt & cpu_lowpwr_i) begin
      exited_lp_r <= 1'b1;
    end else if (wr & hit(wb_adr_i, bkp_pkg::IDX_WAKE_STATUS) &
                 ~wbyte[bkp_pkg::BIT_EXITED_LP]) begin
      exited_lp_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clear_flag_en_r <= 1'b0;
    end else if (wr & hit(wb_adr_i, bkp_pkg::IDX_FLAG_CLEAR)) begin
      clear_flag_en_r <= wbyte[bkp_pkg::BIT_CLEAR_FLAG_EN];
    end
  end

  // Interrupt events
  assign int_event[bkp_pkg::INT_MATCH] = cmp_if.match;
  assign int_event[bkp_pkg::INT_BREAK] = start_nxt;
  assign int_event[bkp_pkg::INT_WAKE]  = start_nxt & cpu_lowpwr_i;

  bkp_irq u_irq (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .event_i   (int_event),
    .wr_stat_i (wr & hit(wb_adr_i, bkp_pkg::IDX_INT_STATUS)),
    .wr_mask_i (wr & hit(wb_adr_i, bkp_pkg::IDX_INT_MASK)),
    .wdata_i   (wbyte[bkp_pkg::INT_W-1:0]),
    .status_o  (int_status),
    .mask_o    (int_mask),
    .irq_o     (irq_o)
  );

  // Bus answer: one wait state, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r   <= 1'b0;
      rdata_r <= bkp_pkg::RST_DATA;
    end else begin
      ack_r   <= req;
      rdata_r <= bkp_pkg::RST_DATA;
      if (req & ~wb_we_i) begin
        if (hit(wb_adr_i, bkp_pkg::IDX_STATUS_CTRL)) begin
          rdata_r[bkp_pkg::BIT_BP_ENABLE]    <= bp_enable_r;
          rdata_r[bkp_pkg::BIT_BREAK_ACTIVE] <= break_active_r;
        end else if (hit(wb_adr_i, bkp_pkg::IDX_BP_HIGH)) begin
          rdata_r[7:0] <= bp_high_r;
        end else if (hit(wb_adr_i, bkp_pkg::IDX_BP_LOW)) begin
          rdata_r[7:0] <= bp_low_r;
        end else if (hit(wb_adr_i, bkp_pkg::IDX_WAKE_STATUS)) begin
          rdata_r[bkp_pkg::BIT_EXITED_LP] <= exited_lp_r;
        end else if (hit(wb_adr_i, bkp_pkg::IDX_FLAG_CLEAR)) begin
          rdata_r[bkp_pkg::BIT_CLEAR_FLAG_EN] <= clear_flag_en_r;
        end else if (hit(wb_adr_i, bkp_pkg::IDX_INT_STATUS)) begin
          rdata_r[bkp_pkg::INT_W-1:0] <= int_status;
        end else if (hit(wb_adr_i, bkp_pkg::IDX_INT_MASK)) begin
          rdata_r[bkp_pkg::INT_W-1:0] <= int_mask;
        end
      end
    end
  end

  assign wb_ack_o     = ack_r;
  assign wb_dat_o     = rdata_r;
  assign bkp_match_o  = cmp_if.match;
  assign brk_start_o  = brk_start_r;
  assign brk_state_o  = in_break_r;
  assign timer_stop_o = in_break_r;
  assign clr_allow_o  = clr_allow_r;

endmodule : bkp_top
